//--- mbe_cfg.svh
// Constants of the byte instruction execution block
// Assumes inclusion by the design modules and the bench
`ifndef MBE_CFG_SVH
`define MBE_CFG_SVH
`define MBE_ACC_RST     8'h00
`define MBE_FLAG_RST    1'b0
`define MBE_TBL_RST     8'h00
`define MBE_DAA_LO      8'h06
`define MBE_DAA_HI      8'h60
`define MBE_NIB_LIMIT   4'h9
`define MBE_LAST_PAGE   8'hff
`define MBE_ZERO_BYTE   8'h00
`define MBE_READ_WAIT   2'h1
`endif

//--- mbe_pkg.sv
// Types for the byte instruction execution block
// Assumes mbe_cfg.svh holds the numeric constants
package mbe_pkg;
  typedef enum logic [4:0] {
    mbe_op_nibble_exchange          = 5'h00,
    mbe_op_nibble_exchange_to_acc   = 5'h01,
    mbe_op_skip_when_zero           = 5'h02,
    mbe_op_copy_then_skip_when_zero = 5'h03,
    mbe_op_skip_when_bit_zero       = 5'h04,
    mbe_op_paged_table_read         = 5'h05,
    mbe_op_last_page_table_read     = 5'h06,
    mbe_op_preincrement_table_read  = 5'h07,
    mbe_op_preincrement_last_page_read = 5'h08,
    mbe_op_xor_to_acc               = 5'h09,
    mbe_op_exclusive_or_to_memory   = 5'h0a,
    mbe_op_xor_immediate            = 5'h0b,
    mbe_op_long_add_with_carry      = 5'h0c,
    mbe_op_long_add_with_carry_to_memory = 5'h0d,
    mbe_op_long_add                 = 5'h0e,
    mbe_op_long_add_to_memory       = 5'h0f,
    mbe_op_long_bitwise_and         = 5'h10,
    mbe_op_long_bitwise_and_to_memory = 5'h11,
    mbe_op_long_clear               = 5'h12,
    mbe_op_long_clear_bit           = 5'h13,
    mbe_op_long_complement          = 5'h14,
    mbe_op_long_complement_to_acc   = 5'h15,
    mbe_op_long_decimal_adjust      = 5'h16,
    mbe_op_long_decrement           = 5'h17,
    mbe_op_long_decrement_to_acc    = 5'h18,
    mbe_op_long_increment           = 5'h19,
    mbe_op_long_increment_to_acc    = 5'h1a,
    mbe_op_long_move_to_acc         = 5'h1b,
    mbe_op_long_move_to_memory      = 5'h1c,
    mbe_op_long_bitwise_or          = 5'h1d,
    mbe_op_long_bitwise_or_to_memory = 5'h1e
  } mbe_op_t;

  typedef enum logic [1:0] {
    mbe_st_idle  = 2'b00,
    mbe_st_fetch = 2'b01,
    mbe_st_wait  = 2'b11,
    mbe_st_dummy = 2'b10
  } mbe_state_t;

  typedef struct packed {
    logic       carry;
    logic       half_carry_flag;
    logic       overflow;
    logic       zero;
    logic       signed_carry_flag;
  } mbe_flags_t;
endpackage

//--- mbe_prog_if.sv
// Program memory read channel between the datapath and its table reader
// Assumes one clock shared by both ends
`timescale 1ns/100ps
interface mbe_prog_if;
  logic        req;
  logic [15:0] addr;
  logic        done;
  logic [15:0] word;
  modport core (output req, output addr, input done, input word);
  modport rdr  (input req, input addr, output done, output word);
endinterface

//--- mbe_table_reader.sv
// Table reader: captures a program word into a register
// Assumes program memory answers one cycle after its address
`timescale 1ns/100ps
`include "mbe_cfg.svh"
module mbe_table_reader
  import mbe_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  mbe_prog_if.rdr           chan,
  output      logic [15:0]  pm_addr,
  input  wire logic [15:0]  pm_data
);
  typedef struct packed {
    logic [1:0]  cnt;
    logic        busy;
    logic        done;
    logic [15:0] addr;
    logic [15:0] word;
  } mbe_rdr_t;

  mbe_rdr_t st;
  mbe_rdr_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (chan.req && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.addr = chan.addr;
      next_st.cnt  = `MBE_READ_WAIT;
    end else if (st.busy) begin
      if (st.cnt == 2'h0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.word = pm_data;
      end else begin
        next_st.cnt = st.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pm_addr   = st.addr;
  assign chan.done = st.done;
  assign chan.word = st.word;
endmodule

//--- mbe_exec.sv
// Execution datapath for nibble swap, zero skips, table reads, XOR and long forms
// Assumes data memory read data arrive with the operation; one strobe per op
`timescale 1ns/100ps
`include "mbe_cfg.svh"
module mbe_exec
  import mbe_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              op_valid,
  input  wire mbe_op_t           op_code,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [2:0]        op_bit,
  input  wire logic [7:0]        op_imm,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic [15:0]       pm_data,
  output      logic [15:0]       pm_addr,
  output      logic              mem_we,
  output      logic [ADDR_W-1:0] mem_waddr,
  output      logic [7:0]        mem_wdata,
  output      logic [7:0]        acc,
  output      mbe_flags_t        flags,
  output      logic [7:0]        table_pointer_low,
  output      logic [7:0]        table_pointer_high,
  output      logic [7:0]        table_read_high_latch,
  output      logic              skip_taken,
  output      logic              dummy_cycle,
  output      logic              op_done,
  output      logic              busy
);
  typedef struct packed {
    mbe_state_t        state;
    logic [7:0]        acc;
    mbe_flags_t        flags;
    logic [7:0]        tlo;
    logic [7:0]        thi;
    logic [7:0]        latch;
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [7:0]        wdata;
    logic              skip;
    logic              dummy;
    logic              done;
    logic              req;
    logic [15:0]       raddr;
    logic              bsy;
  } mbe_core_t;

  mbe_core_t st;
  mbe_core_t next_st;
  mbe_prog_if chan ();

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    return v == `MBE_ZERO_BYTE;
  endfunction

  // Adder with flag derivation shared by both add forms
  function automatic mbe_flags_t add_flags(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin,
                                           input mbe_flags_t f);
    logic [8:0] s;
    logic [4:0] h;
    mbe_flags_t r;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r = f;
    r.carry             = s[8];
    r.half_carry_flag   = h[4];
    r.overflow          = (a[7] == b[7]) && (s[7] != a[7]);
    r.zero              = is_zero(s[7:0]);
    r.signed_carry_flag = s[7] ^ r.overflow;
    return r;
  endfunction

  always_comb begin
    logic [7:0] res;
    logic [7:0] adj;
    logic [8:0] dsum;
    res  = 8'h00;
    adj  = 8'h00;
    dsum = 9'h000;
    next_st       = st;
    next_st.we    = 1'b0;
    next_st.skip  = 1'b0;
    next_st.dummy = 1'b0;
    next_st.done  = 1'b0;
    next_st.req   = 1'b0;
    case (st.state)
      mbe_st_idle: begin
        if (op_valid) begin
          next_st.waddr = op_addr;
          next_st.done  = 1'b1;
          case (op_code)
            mbe_op_nibble_exchange: begin
              next_st.we    = 1'b1;
              next_st.wdata = swap_nib(mem_rdata);
            end
            mbe_op_nibble_exchange_to_acc: begin
              next_st.acc = swap_nib(mem_rdata);
            end
            mbe_op_skip_when_zero: begin
              next_st.skip = is_zero(mem_rdata);
            end
            mbe_op_copy_then_skip_when_zero: begin
              next_st.acc  = mem_rdata;
              next_st.skip = is_zero(mem_rdata);
            end
            mbe_op_skip_when_bit_zero: begin
              next_st.skip = !mem_rdata[op_bit];
            end
            mbe_op_paged_table_read: begin
              next_st.raddr = {st.thi, st.tlo};
            end
            mbe_op_last_page_table_read: begin
              next_st.raddr = {`MBE_LAST_PAGE, st.tlo};
            end
            mbe_op_preincrement_table_read: begin
              next_st.tlo   = st.tlo + 8'h01;
              next_st.raddr = {st.thi, st.tlo + 8'h01};
            end
            mbe_op_preincrement_last_page_read: begin
              next_st.tlo   = st.tlo + 8'h01;
              next_st.raddr = {`MBE_LAST_PAGE, st.tlo + 8'h01};
            end
            mbe_op_xor_to_acc, mbe_op_xor_immediate: begin
              res = st.acc ^ (op_code == mbe_op_xor_immediate ? op_imm : mem_rdata);
              next_st.acc        = res;
              next_st.flags.zero = is_zero(res);
            end
            mbe_op_exclusive_or_to_memory: begin
              res = st.acc ^ mem_rdata;
              next_st.we         = 1'b1;
              next_st.wdata      = res;
              next_st.flags.zero = is_zero(res);
            end
            mbe_op_long_add_with_carry, mbe_op_long_add_with_carry_to_memory: begin
              res = st.acc + mem_rdata + {7'h00, st.flags.carry};
              next_st.flags = add_flags(st.acc, mem_rdata, st.flags.carry, st.flags);
              if (op_code == mbe_op_long_add_with_carry) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_add, mbe_op_long_add_to_memory: begin
              res = st.acc + mem_rdata;
              next_st.flags = add_flags(st.acc, mem_rdata, 1'b0, st.flags);
              if (op_code == mbe_op_long_add) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_bitwise_and, mbe_op_long_bitwise_and_to_memory: begin
              res = st.acc & mem_rdata;
              next_st.flags.zero = is_zero(res);
              if (op_code == mbe_op_long_bitwise_and) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_clear: begin
              next_st.we    = 1'b1;
              next_st.wdata = `MBE_ZERO_BYTE;
            end
            mbe_op_long_clear_bit: begin
              res = mem_rdata;
              res[op_bit] = 1'b0;
              next_st.we    = 1'b1;
              next_st.wdata = res;
            end
            mbe_op_long_complement, mbe_op_long_complement_to_acc: begin
              res = ~mem_rdata;
              next_st.flags.zero = is_zero(res);
              if (op_code == mbe_op_long_complement_to_acc) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_decimal_adjust: begin
              if (st.acc[3:0] > `MBE_NIB_LIMIT || st.flags.half_carry_flag) begin
                adj = adj | `MBE_DAA_LO;
              end
              if (st.acc[7:4] > `MBE_NIB_LIMIT || st.flags.carry) begin
                adj = adj | `MBE_DAA_HI;
              end
              dsum = {1'b0, st.acc} + {1'b0, adj};
              next_st.we          = 1'b1;
              next_st.wdata       = dsum[7:0];
              next_st.flags.carry = st.flags.carry | dsum[8];
            end
            mbe_op_long_decrement, mbe_op_long_decrement_to_acc: begin
              res = mem_rdata - 8'h01;
              next_st.flags.zero = is_zero(res);
              if (op_code == mbe_op_long_decrement_to_acc) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_increment, mbe_op_long_increment_to_acc: begin
              res = mem_rdata + 8'h01;
              next_st.flags.zero = is_zero(res);
              if (op_code == mbe_op_long_increment_to_acc) begin
                next_st.acc = res;
              end else begin
                next_st.we    = 1'b1;
                next_st.wdata = res;
              end
            end
            mbe_op_long_move_to_acc: begin
              next_st.acc = mem_rdata;
            end
            mbe_op_long_move_to_memory: begin
              next_st.we    = 1'b1;
              next_st.wdata = st.acc;
            end
            mbe_op_long_bitwise_or: begin
              res = st.acc | mem_rdata;
              next_st.acc        = res;
              next_st.flags.zero = is_zero(res);
            end
            mbe_op_long_bitwise_or_to_memory: begin
              res = st.acc | mem_rdata;
              next_st.we         = 1'b1;
              next_st.wdata      = res;
              next_st.flags.zero = is_zero(res);
            end
            default: begin
              next_st.done = 1'b1;
            end
          endcase
          // Table reads finish later, taken skips add the dummy cycle
          case (op_code)
            mbe_op_paged_table_read, mbe_op_last_page_table_read,
            mbe_op_preincrement_table_read, mbe_op_preincrement_last_page_read: begin
              next_st.done  = 1'b0;
              next_st.req   = 1'b1;
              next_st.state = mbe_st_fetch;
            end
            mbe_op_skip_when_zero, mbe_op_copy_then_skip_when_zero,
            mbe_op_skip_when_bit_zero: begin
              if (next_st.skip) begin
                next_st.done  = 1'b0;
                next_st.state = mbe_st_dummy;
              end
            end
            default: begin
              next_st.state = mbe_st_idle;
            end
          endcase
        end
      end
      mbe_st_fetch: begin
        next_st.state = mbe_st_wait;
      end
      mbe_st_wait: begin
        if (chan.done) begin
          next_st.we    = 1'b1;
          next_st.wdata = chan.word[7:0];
          next_st.latch = chan.word[15:8];
          next_st.done  = 1'b1;
          next_st.state = mbe_st_idle;
        end
      end
      mbe_st_dummy: begin
        next_st.dummy = 1'b1;
        next_st.done  = 1'b1;
        next_st.state = mbe_st_idle;
      end
      default: begin
        next_st.state = mbe_st_idle;
      end
    endcase
    // Busy registered beside the state
    next_st.bsy = (next_st.state != mbe_st_idle);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st       <= '0;
      st.acc   <= `MBE_ACC_RST;
      st.tlo   <= `MBE_TBL_RST;
      st.thi   <= `MBE_TBL_RST;
      st.latch <= `MBE_TBL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign chan.req  = st.req;
  assign chan.addr = st.raddr;

  mbe_table_reader u_reader (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .chan     (chan),
    .pm_addr  (pm_addr),
    .pm_data  (pm_data)
  );

  assign mem_we                = st.we;
  assign mem_waddr             = st.waddr;
  assign mem_wdata             = st.wdata;
  assign acc                   = st.acc;
  assign flags                 = st.flags;
  assign table_pointer_low     = st.tlo;
  assign table_pointer_high    = st.thi;
  assign table_read_high_latch = st.latch;
  assign skip_taken            = st.skip;
  assign dummy_cycle           = st.dummy;
  assign op_done               = st.done;
  assign busy                  = st.bsy;
endmodule

//--- mbe_exec_checker.sv
// Port checks for the byte execution datapath
// Assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module mbe_exec_checker
  import mbe_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       op_valid,
  input wire mbe_op_t    op_code,
  input wire logic [2:0] op_bit,
  input wire logic [7:0] mem_rdata,
  input wire logic       mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire mbe_flags_t flags,
  input wire logic       skip_taken,
  input wire logic       dummy_cycle,
  input wire logic       op_done,
  input wire logic       busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] rd_q;
  logic [7:0] acc_q;
  mbe_flags_t fl_q;
  logic       sel_q;
  wire        tk = op_valid && !busy;
  // Operands as seen at the taking edge
  always_ff @(posedge core_clk) begin
    rd_q <= mem_rdata;
    acc_q <= acc;
    fl_q <= flags;
    sel_q <= mem_rdata[op_bit];
  end
  chk_swap_in_place: assert property (
    tk && op_code == mbe_op_nibble_exchange |=> mem_we && flags == fl_q
    && mem_wdata == {rd_q[3:0], rd_q[7:4]}) else $error("in-place swap wrong");
  chk_swap_to_acc: assert property (
    tk && op_code == mbe_op_nibble_exchange_to_acc |=> !mem_we && flags == fl_q
    && acc == {rd_q[3:0], rd_q[7:4]}) else $error("swap to acc wrong");
  chk_zero_skip: assert property (
    tk && op_code == mbe_op_skip_when_zero |=> skip_taken == (rd_q == 8'h00))
    else $error("zero skip wrong");
  chk_bit_skip: assert property (
    tk && op_code == mbe_op_skip_when_bit_zero |=> skip_taken == !sel_q)
    else $error("bit skip wrong");
  chk_skip_dummy: assert property (
    skip_taken |-> busy ##1 (dummy_cycle && op_done)) else $error("no dummy cycle");
  chk_table_span: assert property (
    tk && op_code inside {[mbe_op_paged_table_read:mbe_op_preincrement_last_page_read]}
    |=> busy [*4] ##1 (mem_we && op_done && !busy)) else $error("table read timing");
  chk_xor_zero: assert property (
    tk && op_code == mbe_op_xor_to_acc |=> acc == (acc_q ^ rd_q)
    && flags.zero == (acc == 8'h00) && $stable(flags.carry)) else $error("xor wrong");
  chk_add_sum: assert property (
    tk && op_code == mbe_op_long_add |=> acc == acc_q + rd_q
    && flags.carry == ({1'b0, acc_q} + {1'b0, rd_q} > 9'h0ff)) else $error("add wrong");
  chk_clear_byte: assert property (
    tk && op_code == mbe_op_long_clear |=> mem_we && mem_wdata == 8'h00
    && flags == fl_q) else $error("clear wrong");
  cover property (skip_taken);
  cover property (tk && op_code == mbe_op_preincrement_last_page_read);
  cover property (op_valid && busy);
endmodule
bind mbe_exec mbe_exec_checker chk (
  .core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
  .op_bit(op_bit), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .acc(acc), .flags(flags), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
  .op_done(op_done), .busy(busy)
);

//--- mbe_mem_model.sv
// Data memory and program memory beside the datapath
// Assumes data reads follow the address at once, program words one edge late
`timescale 1ns/100ps
module mbe_mem_model
  import mbe_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [11:0] op_addr,
  input  wire logic        mem_we,
  input  wire logic [11:0] mem_waddr,
  input  wire logic [7:0]  mem_wdata,
  output      logic [7:0]  mem_rdata,
  input  wire logic [15:0] pm_addr,
  output      logic [15:0] pm_data
);
  logic [7:0] dmem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      dmem[i] = i[7:0];
    end
  end
  assign mem_rdata = dmem[op_addr];
  // Program word is a fixed scramble of its address
  always @(posedge core_clk) begin
    if (mem_we) begin
      dmem[mem_waddr] <= mem_wdata;
    end
    pm_data <= {pm_addr[7:0] ^ 8'ha5, pm_addr[15:8] ^ pm_addr[7:0]};
  end
endmodule

//--- mbe_exec_tb_top.sv
// Self-checking bench for the byte execution datapath
// Assumes the memory model beside it and the checker bound to the design
`timescale 1ns/100ps
`include "mbe_cfg.svh"
module mbe_exec_tb_top
  import mbe_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    mbe_flags_t  f;
    logic        w;
    logic [7:0]  d;
    logic [11:0] wa;
    logic        s;
    logic [7:0]  l;
    logic [15:0] t;
  } mbe_note_t;
  logic        core_clk, rst_b, op_valid, mem_we, skip_taken, dummy_cycle, op_done, busy;
  mbe_op_t     op_code;
  logic [11:0] op_addr, mem_waddr, ad;
  logic [2:0]  op_bit, b;
  logic [7:0]  op_imm, mem_rdata, mem_wdata, acc, ptr_lo, ptr_hi, hi_latch;
  logic [7:0]  rd, im, ea, el, tl;
  logic [15:0] pm_addr, pm_data;
  mbe_flags_t  flags, ef;
  logic [31:0] seed, r;
  mbe_note_t   n;
  mbe_note_t   q[$];
  int          fails, checks;
  mbe_exec #(.ADDR_W(12)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .mem_rdata(mem_rdata),
    .pm_data(pm_data), .pm_addr(pm_addr), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .acc(acc), .flags(flags), .table_pointer_low(ptr_lo),
    .table_pointer_high(ptr_hi), .table_read_high_latch(hi_latch),
    .skip_taken(skip_taken), .dummy_cycle(dummy_cycle), .op_done(op_done), .busy(busy)
  );
  mbe_mem_model mdl (
    .core_clk(core_clk), .op_addr(op_addr), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pm_addr(pm_addr), .pm_data(pm_data)
  );
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(mbe_note_t seen, mbe_note_t exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wm(logic [7:0] v);
    n.w = 1'b1;
    n.d = v;
    n.wa = ad;
  endtask
  task automatic put(logic [7:0] v, logic tm);
    if (tm) wm(v);
    else ea = v;
    ef.zero = v == 8'h00;
  endtask
  task automatic add(logic ci, logic tm);
    logic [8:0] t;
    logic [4:0] h;
    t = ea + rd + ci;
    h = ea[3:0] + rd[3:0] + ci;
    ef.carry = t[8];
    ef.half_carry_flag = h[4];
    ef.overflow = ea[7] == rd[7] && t[7] != ea[7];
    ef.signed_carry_flag = t[7] ^ ef.overflow;
    put(t[7:0], tm);
  endtask
  // Work out the expected note, then present the operation
  task automatic issue(logic [4:0] c);
    logic [8:0]  t;
    logic [15:0] pa;
    int          k;
    r = rnd();
    ad = r[27:16];
    b = r[14:12];
    im = r[31:24];
    rd = (r[9:8] == 2'b00) ? 8'h00 : r[7:0];
    n = '0;
    k = 0;
    case (c)
      mbe_op_nibble_exchange: wm({rd[3:0], rd[7:4]});
      mbe_op_nibble_exchange_to_acc: ea = {rd[3:0], rd[7:4]};
      mbe_op_skip_when_zero: n.s = rd == 8'h00;
      mbe_op_copy_then_skip_when_zero: begin
        ea = rd;
        n.s = rd == 8'h00;
      end
      mbe_op_skip_when_bit_zero: n.s = !rd[b];
      mbe_op_paged_table_read, mbe_op_last_page_table_read,
      mbe_op_preincrement_table_read, mbe_op_preincrement_last_page_read: begin
        if (c >= 5'h07) tl = tl + 8'h01;
        pa = {(c == 5'h06 || c == 5'h08) ? `MBE_LAST_PAGE : 8'h00, tl};
        pa = {pa[7:0] ^ 8'ha5, pa[15:8] ^ pa[7:0]};
        wm(pa[7:0]);
        el = pa[15:8];
      end
      mbe_op_xor_to_acc: put(ea ^ rd, 1'b0);
      mbe_op_exclusive_or_to_memory: put(ea ^ rd, 1'b1);
      mbe_op_xor_immediate: put(ea ^ im, 1'b0);
      mbe_op_long_add_with_carry: add(ef.carry, 1'b0);
      mbe_op_long_add_with_carry_to_memory: add(ef.carry, 1'b1);
      mbe_op_long_add: add(1'b0, 1'b0);
      mbe_op_long_add_to_memory: add(1'b0, 1'b1);
      mbe_op_long_bitwise_and: put(ea & rd, 1'b0);
      mbe_op_long_bitwise_and_to_memory: put(ea & rd, 1'b1);
      mbe_op_long_clear: wm(8'h00);
      mbe_op_long_clear_bit: wm(rd & ~(8'h01 << b));
      mbe_op_long_complement: put(~rd, 1'b1);
      mbe_op_long_complement_to_acc: put(~rd, 1'b0);
      mbe_op_long_decimal_adjust: begin
        t = ea + ((ea[3:0] > 4'h9 || ef.half_carry_flag) ? 8'h06 : 8'h00)
          + ((ea[7:4] > 4'h9 || ef.carry) ? 8'h60 : 8'h00);
        ef.carry = ef.carry | t[8];
        wm(t[7:0]);
      end
      mbe_op_long_decrement: put(rd - 8'h01, 1'b1);
      mbe_op_long_decrement_to_acc: put(rd - 8'h01, 1'b0);
      mbe_op_long_increment: put(rd + 8'h01, 1'b1);
      mbe_op_long_increment_to_acc: put(rd + 8'h01, 1'b0);
      mbe_op_long_move_to_acc: ea = rd;
      mbe_op_long_move_to_memory: wm(ea);
      mbe_op_long_bitwise_or: put(ea | rd, 1'b0);
      mbe_op_long_bitwise_or_to_memory: put(ea | rd, 1'b1);
      default: ;
    endcase
    n.a = ea;
    n.f = ef;
    n.l = el;
    n.t = {8'h00, tl};
    q.push_back(n);
    mdl.dmem[ad] = rd;
    op_code = mbe_op_t'(c);
    op_addr = ad;
    op_bit = b;
    op_imm = im;
    op_valid = 1'b1;
    @(posedge core_clk);
    #1;
    // A second request while busy must be ignored
    while (busy === 1'b1) begin
      op_code = mbe_op_long_clear;
      k++;
      if (k > 8) begin
        fails++;
        report_and_stop();
      end
      @(posedge core_clk);
      #1;
    end
  endtask
  // Gather what one operation produced and compare at its completion
  initial begin
    mbe_note_t o;
    mbe_note_t e;
    o = '0;
    forever begin
      @(negedge core_clk);
      if (mem_we === 1'b1) begin
        o.w = 1'b1;
        o.d = mem_wdata;
        o.wa = mem_waddr;
      end
      if (skip_taken === 1'b1) o.s = 1'b1;
      if (op_done === 1'b1) begin
        o.a = acc;
        o.f = flags;
        o.l = hi_latch;
        o.t = {ptr_hi, ptr_lo};
        e = (q.size() == 0) ? mbe_note_t'('1) : q.pop_front();
        chk(o, e);
        o = '0;
      end
    end
  end
  initial begin
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = mbe_op_nibble_exchange;
    op_addr = 12'h000;
    op_bit = 3'h0;
    op_imm = 8'h00;
    fails = 0;
    checks = 0;
    seed = 32'h0000004c;
    ea = 8'h00;
    ef = '0;
    el = 8'h00;
    tl = 8'h00;
    repeat (16) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 32; i++) issue(5'(i));
    for (int i = 0; i < 600; i++) issue(5'(rnd() % 32));
    op_valid = 1'b0;
    repeat (8) @(posedge core_clk);
    chk(mbe_note_t'(q.size()), '0);
    report_and_stop();
  end
endmodule
